// [test/ceia_irq_ctrl_model.sv]
`timescale 1ns/1ps

module ceia_irq_ctrl_model (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_b_i,
  // commands from the bench
  input  wire logic                               go_i,
  input  wire logic                               drop_i,
  input  wire ceia_pkg::ceia_ext_irq_ctrl_iface_t want_i,
  // request side facing the exception unit
  input  wire logic                               ack_i,
  output logic                                    valid_o,
  output ceia_pkg::ceia_ext_irq_ctrl_iface_t      req_o
);
  // the processor side is built with shadow register sets
  localparam logic SHADOW_SETS = 1'b1;
  logic [5:0] set_out;

  // without shadow sets the controller must never ask for a set other than zero
  assign set_out = SHADOW_SETS ? want_i.req_reg_set : 6'h00;

  // request held until acked or withdrawn; idle fields keep toggling so stale values never look valid
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      valid_o <= 1'b0;
      req_o   <= '0;
    end
    else if (ack_i || drop_i)
    begin
      valid_o <= 1'b0;
      req_o   <= ~req_o;
    end
    else if (go_i)
    begin
      valid_o <= 1'b1;
      req_o   <= '{want_i.req_handler_addr, set_out, want_i.req_irq_level, want_i.req_nonmaskable};
    end
    else if (!valid_o)
      req_o <= ~req_o;
  end
endmodule // ceia_irq_ctrl_model

// [test/test_ceia_exc_unit.sv]
`timescale 1ns/1ps

module test_ceia_exc_unit;
  // ****************
  // signals
  // ****************
  logic clk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, exc_i = 1'b0, tlb_miss_i = 1'b0;
  logic go = 1'b0, drop = 1'b0, valid, ack, redirect_o, irq_o, hreadyout_o, rd_dp = 1'b0;
  logic hresp, eret = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] hwdata_i = 32'h0000_0000, ret_i = 32'h0000_0000, hrdata_o, redirect_pc_o, ra;
  ceia_pkg::ceia_ext_irq_ctrl_iface_t want = '0, req;
  logic [31:0] rq[$], pq[$];
  int n_errors = 0, check_count = 0, cyc = 0, ack_seen = 0, ack_exp = 0;
  logic [15:0] st_tab[7] = '{16'h0000, 16'h0087, 16'h0087, 16'h2087, 16'h0087, 16'h4000, 16'h0000};
  logic [5:0] lvl_tab[7] = '{6'h05, 6'h03, 6'h04, 6'h04, 6'h04, 6'h00, 6'h00};
  logic [5:0] set_tab[7] = '{6'h01, 6'h02, 6'h01, 6'h01, 6'h02, 6'h00, 6'h00};
  logic [6:0] ani_tab = 7'b001_0000, nmi_tab = 7'b110_0000, acc_tab = 7'b101_1000;

  // clock at 40 MHz
  always #12.5 clk_i = ~clk_i;

  ceia_exc_unit uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp), .irq_req_valid_i(valid), .irq_req_i(req),
    .irq_ack_o(ack), .exc_i(exc_i), .tlb_miss_i(tlb_miss_i), .return_addr_i(ret_i), .eret_i(eret),
    .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o), .irq_o(irq_o));

  ceia_irq_ctrl_model ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .drop_i(drop), .want_i(want),
    .ack_i(ack), .valid_o(valid), .req_o(req));

  // ****************
  // checking
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // results land one edge after they stand; an unexpected result is compared against its own inverse
  always @(posedge clk_i)
  begin
    if (rd_dp && hreadyout_o === 1'b1)
    begin
      chk(hrdata_o, rq.size() ? rq.pop_front() : ~hrdata_o);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
    end
    // an acknowledge must come with the jump to the handler
    if (ack === 1'b1)
    begin
      ack_seen++;
      chk({31'h0000_0000, redirect_o}, 32'h0000_0001);
    end
    if (hreadyout_o === 1'b1)
      rd_dp = hsel_i && htrans_i[1] && !hwrite_i;
    if (redirect_o === 1'b1)
      chk(redirect_pc_o, pq.size() ? pq.pop_front() : ~redirect_pc_o);
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ****************
  // drivers
  // ****************
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  // one request; an accepted one must redirect to its handler
  task irq(input logic n, input logic [5:0] l, input logic [5:0] s, input logic acc);
    want <= '{$urandom & 32'hFFFF_FFFC, s, l, n};
    @(posedge clk_i);
    if (acc)
    begin
      pq.push_back(want.req_handler_addr);
      ack_exp++;
    end
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_i);
    drop <= 1'b1;
    @(posedge clk_i);
    drop <= 1'b0;
  endtask

  task pulse(input logic t, input logic [31:0] pc);
    pq.push_back(pc);
    if (t)
      tlb_miss_i <= 1'b1;
    else
      exc_i <= 1'b1;
    @(posedge clk_i);
    tlb_miss_i <= 1'b0;
    exc_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ****************
  // scenarios
  // ****************
  initial
  begin
    void'($urandom(16709));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    // reset values, fixed vectors, unmapped place
    bus(8'h10, 1'b1, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0020);
    rd(8'h14, 32'h0000_0100);
    rd(8'h04, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    // acceptance table, status after each take or refusal
    for (int i = 0; i < 7; i++)
    begin
      bus(8'h04, 1'b1, {31'h0000_0000, ani_tab[i]});
      bus(8'h00, 1'b1, {16'h0000, st_tab[i]});
      irq(nmi_tab[i], lvl_tab[i], set_tab[i], acc_tab[i]);
      if (acc_tab[i])
        rd(8'h00, {16'h0000, st_tab[i][15], nmi_tab[i], 1'b0, set_tab[i], lvl_tab[i], ani_tab[i]});
      else
        rd(8'h00, {16'h0000, st_tab[i]});
    end
    // fast miss, then double miss and plain exception with state preserved
    bus(8'h04, 1'b1, 32'h0000_0000);
    bus(8'h00, 1'b1, 32'h0000_0087);
    ra = $urandom;
    ret_i <= ra;
    pulse(1'b1, 32'h0000_0100);
    rd(8'h00, 32'h0000_8086);
    ret_i <= ~ra;
    pulse(1'b1, 32'h0000_0020);
    pulse(1'b0, 32'h0000_0020);
    irq(1'b1, 6'h00, 6'h00, 1'b1);
    rd(8'h08, 32'h0000_0087);
    rd(8'h0C, ra);
    rd(8'h00, 32'h0000_C000);
    // return from exception restores the saved status
    eret <= 1'b1;
    @(posedge clk_i);
    eret <= 1'b0;
    rd(8'h00, 32'h0000_0087);
    // event status, mask and interrupt line
    rd(8'h18, 32'h0000_000F);
    bus(8'h1C, 1'b1, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h0000_0001);
    bus(8'h18, 1'b1, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h0000_0000);
    rd(8'h18, 32'h0000_000B);
    repeat (4) @(posedge clk_i);
    chk(32'(rq.size() + pq.size()), 32'h0000_0000);
    chk(ack_seen, ack_exp);
    conclude();
  end
endmodule // test_ceia_exc_unit

// [verilog/ceia_defines.svh]
`ifndef CEIA_DEFINES_SVH
`define CEIA_DEFINES_SVH

// register byte offsets
`define CEIA_OFS_STATUS   8'h00
`define CEIA_OFS_CONFIG   8'h04
`define CEIA_OFS_SAVED    8'h08
`define CEIA_OFS_RETADDR  8'h0C
`define CEIA_OFS_GENVEC   8'h10
`define CEIA_OFS_TLBVEC   8'h14
`define CEIA_OFS_EVSTAT   8'h18
`define CEIA_OFS_EVMASK   8'h1C

// vectors fixed when the core is configured
`define CEIA_GEN_VECTOR   32'h0000_0020
`define CEIA_TLB_VECTOR   32'h0000_0100

// field widths and reset values
`define CEIA_LVL_W        6
`define CEIA_SET_W        6
`define CEIA_EV_W         4
`define CEIA_STAT_RST     16'h0000
`define CEIA_CFG_RST      1'b0

// event bit positions
`define CEIA_EV_IRQ       0
`define CEIA_EV_NMI       1
`define CEIA_EV_FTLB      2
`define CEIA_EV_DTLB      3

`endif

// [verilog/ceia_exc_unit.sv]
//
// Notes on behaviour
// - general vector fixed, no software write path
// - only noninterrupt exceptions use general vector
// - only fast tlb misses use tlb vector
// - nmi taken unless an nmi is in progress
// - maskable needs enable and higher level
// - maskable needs other set or nest enable
// - auto nesting config resets to zero
// - auto nesting keeps enable on maskable take
// - no auto nesting clears enable on take
// - software writing enable one re-enables interrupts
// - tlb miss with flag clear sets it, fast vector
// - flag set keeps saved exception state unchanged
`timescale 1ns/1ps
`include "ceia_defines.svh"

module ceia_exc_unit (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_b_i,
  // ahb-lite slave
  input  wire logic                               hsel_i,
  input  wire logic [7:0]                         haddr_i,
  input  wire logic [1:0]                         htrans_i,
  input  wire logic                               hwrite_i,
  input  wire logic [2:0]                         hsize_i,
  input  wire logic [31:0]                        hwdata_i,
  input  wire logic                               hready_i,
  output logic      [31:0]                        hrdata_o,
  output logic                                    hreadyout_o,
  output logic                                    hresp_o,
  // external interrupt controller request
  input  wire logic                               irq_req_valid_i,
  input  wire ceia_pkg::ceia_ext_irq_ctrl_iface_t irq_req_i,
  output logic                                    irq_ack_o,
  // pipeline exception sources
  input  wire logic                               exc_i,
  input  wire logic                               tlb_miss_i,
  input  wire logic [31:0]                        return_addr_i,
  input  wire logic                               eret_i,
  // redirect to the fetch unit and interrupt line
  output logic                                    redirect_o,
  output logic      [31:0]                        redirect_pc_o,
  output logic                                    irq_o
);

  // ********************************************************************
  // bus slave
  // ********************************************************************
  ceia_pkg::ceia_bus_st_t bus_st;
  ceia_pkg::ceia_bus_st_t next_bus_st;
  logic [7:0]             addr;
  logic [7:0]             next_addr;
  logic                   wr_pend;
  logic                   next_wr_pend;
  logic [31:0]            rdata;
  logic [31:0]            next_rdata;
  logic                   hready_q;
  logic                   next_hready_q;
  logic                   wr_now;
  logic [31:0]            rd_mux;

  ceia_pkg::ceia_stat_t   status;
  ceia_pkg::ceia_stat_t   next_status;
  ceia_pkg::ceia_stat_t   saved;
  ceia_pkg::ceia_stat_t   next_saved;
  logic                   auto_nest_cfg;
  logic                   next_auto_nest_cfg;
  logic [31:0]            ret_addr;
  logic [31:0]            next_ret_addr;
  logic [3:0]             ev_stat;
  logic [3:0]             next_ev_stat;
  logic [3:0]             ev_mask;
  logic [3:0]             next_ev_mask;

  // read mux over the register map, unmapped words read zero
  always_comb
  begin
    case (addr)
      `CEIA_OFS_STATUS:  rd_mux = {16'h0000, status};
      `CEIA_OFS_CONFIG:  rd_mux = {31'h0000_0000, auto_nest_cfg};
      `CEIA_OFS_SAVED:   rd_mux = {16'h0000, saved};
      `CEIA_OFS_RETADDR: rd_mux = ret_addr;
      `CEIA_OFS_GENVEC:  rd_mux = `CEIA_GEN_VECTOR;
      `CEIA_OFS_TLBVEC:  rd_mux = `CEIA_TLB_VECTOR;
      `CEIA_OFS_EVSTAT:  rd_mux = {28'h000_0000, ev_stat};
      `CEIA_OFS_EVMASK:  rd_mux = {28'h000_0000, ev_mask};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // reads take one wait state so a read right after a write sees it
  always_comb
  begin
    next_bus_st   = bus_st;
    next_addr     = addr;
    next_wr_pend  = 1'b0;
    next_rdata    = rdata;
    next_hready_q = 1'b1;
    wr_now        = wr_pend;
    case (bus_st)
      ceia_pkg::CEIA_BUS_IDLE:
      begin
        if (hsel_i && htrans_i[1] && hready_i)
        begin
          next_addr = haddr_i;
          if (hwrite_i)
            next_wr_pend = 1'b1;
          else
          begin
            next_bus_st   = ceia_pkg::CEIA_BUS_RWAIT;
            next_hready_q = 1'b0;
          end
        end
      end
      ceia_pkg::CEIA_BUS_RWAIT:
      begin
        next_rdata  = rd_mux;
        next_bus_st = ceia_pkg::CEIA_BUS_RDATA;
      end
      ceia_pkg::CEIA_BUS_RDATA:
      begin
        next_bus_st = ceia_pkg::CEIA_BUS_IDLE;
        if (hsel_i && htrans_i[1])
        begin
          next_addr = haddr_i;
          if (hwrite_i)
            next_wr_pend = 1'b1;
          else
          begin
            next_bus_st   = ceia_pkg::CEIA_BUS_RWAIT;
            next_hready_q = 1'b0;
          end
        end
      end
      default:
        next_bus_st = ceia_pkg::CEIA_BUS_IDLE;
    endcase
  end

  // bus registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_st   <= ceia_pkg::CEIA_BUS_IDLE;
      addr     <= 8'h00;
      wr_pend  <= 1'b0;
      rdata    <= 32'h0000_0000;
      hready_q <= 1'b1;
    end
    else
    begin
      bus_st   <= next_bus_st;
      addr     <= next_addr;
      wr_pend  <= next_wr_pend;
      rdata    <= next_rdata;
      hready_q <= next_hready_q;
    end
  end

  assign hrdata_o    = rdata;
  assign hreadyout_o = hready_q;
  assign hresp_o     = 1'b0;   // always okay

  // ********************************************************************
  // acceptance and dispatch
  // ********************************************************************
  logic        nmi_ok;
  logic        mask_ok;
  logic        take_irq;
  logic        take_exc;
  logic        fast_tlb;
  logic [3:0]  ev_set;
  logic        redirect_q;
  logic        next_redirect_q;
  logic [31:0] pc_q;
  logic [31:0] next_pc_q;
  logic        ack_q;
  logic        next_ack_q;
  logic        irq_q;

  // acceptance is re-evaluated every cycle; refused requests stay with the controller
  always_comb
  begin
    nmi_ok   = irq_req_i.req_nonmaskable && !status.nmi_in_progress;
    mask_ok  = !irq_req_i.req_nonmaskable && status.irq_enable_bit
               && (irq_req_i.req_irq_level > status.current_irq_level)
               && ((irq_req_i.req_reg_set != status.current_reg_set)
                   || status.same_set_nest_enable);
    // synchronous exceptions win over a request in the same cycle
    take_exc = exc_i || tlb_miss_i;
    take_irq = irq_req_valid_i && (nmi_ok || mask_ok) && !take_exc && !eret_i;
    fast_tlb = tlb_miss_i && !status.exception_in_progress;
  end

  // status, saved state and redirect
  always_comb
  begin
    next_status        = status;
    next_saved         = saved;
    next_ret_addr      = ret_addr;
    next_auto_nest_cfg = auto_nest_cfg;
    next_ev_mask       = ev_mask;
    next_redirect_q    = 1'b0;
    next_pc_q          = pc_q;
    next_ack_q         = 1'b0;
    ev_set             = 4'h0;
    // software writes first, hardware events below override them
    if (wr_now)
    begin
      case (addr)
        `CEIA_OFS_STATUS: next_status = ceia_pkg::ceia_stat_t'(hwdata_i[15:0]);
        `CEIA_OFS_CONFIG: next_auto_nest_cfg = hwdata_i[0];
        `CEIA_OFS_EVMASK: next_ev_mask = hwdata_i[3:0];
        default:          next_ev_mask = ev_mask;
      endcase
    end
    if (take_exc)
    begin
      if (!status.exception_in_progress)
      begin
        next_saved    = status;
        next_ret_addr = return_addr_i;
      end
      next_status.exception_in_progress = 1'b1;
      next_status.irq_enable_bit        = 1'b0;
      next_redirect_q = 1'b1;
      next_pc_q = fast_tlb ? `CEIA_TLB_VECTOR : `CEIA_GEN_VECTOR;
      ev_set[`CEIA_EV_FTLB] = fast_tlb;
      ev_set[`CEIA_EV_DTLB] = tlb_miss_i && status.exception_in_progress;
    end
    else if (take_irq)
    begin
      if (!status.exception_in_progress)
      begin
        next_saved    = status;
        next_ret_addr = return_addr_i;
      end
      // auto nesting keeps maskable handlers preemptible
      next_status.irq_enable_bit = auto_nest_cfg;
      next_status.current_irq_level    = irq_req_i.req_irq_level;
      next_status.current_reg_set      = irq_req_i.req_reg_set;
      next_status.same_set_nest_enable = 1'b0;
      next_status.nmi_in_progress      = irq_req_i.req_nonmaskable;
      next_redirect_q = 1'b1;
      next_pc_q       = irq_req_i.req_handler_addr;
      next_ack_q      = 1'b1;
      ev_set[`CEIA_EV_IRQ] = !irq_req_i.req_nonmaskable;
      ev_set[`CEIA_EV_NMI] = irq_req_i.req_nonmaskable;
    end
    else if (eret_i)
      next_status = saved;
    // sticky events: a set in the clearing cycle wins
    next_ev_stat = (ev_stat & ~((wr_now && addr == `CEIA_OFS_EVSTAT) ? hwdata_i[3:0] : 4'h0)) | ev_set;
  end

  // core state registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      status        <= `CEIA_STAT_RST;
      saved         <= `CEIA_STAT_RST;
      ret_addr      <= 32'h0000_0000;
      auto_nest_cfg <= `CEIA_CFG_RST;
      ev_stat       <= 4'h0;
      ev_mask       <= 4'h0;
      redirect_q    <= 1'b0;
      pc_q          <= 32'h0000_0000;
      ack_q         <= 1'b0;
      irq_q         <= 1'b0;
    end
    else
    begin
      status        <= next_status;
      saved         <= next_saved;
      ret_addr      <= next_ret_addr;
      auto_nest_cfg <= next_auto_nest_cfg;
      ev_stat       <= next_ev_stat;
      ev_mask       <= next_ev_mask;
      redirect_q    <= next_redirect_q;
      pc_q          <= next_pc_q;
      ack_q         <= next_ack_q;
      irq_q         <= |(next_ev_stat & next_ev_mask);
    end
  end

  assign redirect_o    = redirect_q;
  assign redirect_pc_o = pc_q;
  assign irq_ack_o     = ack_q;
  assign irq_o         = irq_q;

  // ********************************************************************
  // checks
  // ********************************************************************
  nmi_refused_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_req_valid_i && irq_req_i.req_nonmaskable && status.nmi_in_progress) |=> !irq_ack_o)
    else $error("nmi accepted while nmi in progress");
  level_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_req_valid_i && !irq_req_i.req_nonmaskable
     && irq_req_i.req_irq_level <= status.current_irq_level) |=> !irq_ack_o)
    else $error("maskable accepted at too low a level");
  same_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (irq_req_valid_i && !irq_req_i.req_nonmaskable && !status.same_set_nest_enable
     && irq_req_i.req_reg_set == status.current_reg_set) |=> !irq_ack_o)
    else $error("same set taken without nest enable");
  nest_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (take_irq && !irq_req_i.req_nonmaskable && auto_nest_cfg) |=> status.irq_enable_bit)
    else $error("enable dropped with auto nesting");
  exc_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take_exc |=> (!status.irq_enable_bit && redirect_o))
    else $error("exception left interrupts enabled");
  fast_tlb_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tlb_miss_i && !status.exception_in_progress)
    |=> (status.exception_in_progress && redirect_pc_o == `CEIA_TLB_VECTOR))
    else $error("fast tlb miss misrouted");
  keep_saved_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (take_exc && status.exception_in_progress) |=> ($stable(saved) && $stable(ret_addr)))
    else $error("saved state overwritten");
  irq_vector_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take_irq |=> (irq_ack_o && redirect_pc_o == $past(irq_req_i.req_handler_addr)))
    else $error("interrupt not sent to its handler");
  nest_reset_a: assert property (@(posedge clk_i)
    !rst_b_i |=> (!auto_nest_cfg || $past(rst_b_i)))
    else $error("auto nesting not zero after reset");
  reenable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_now && addr == `CEIA_OFS_STATUS && hwdata_i[0] && !take_exc && !take_irq && !eret_i)
    |=> status.irq_enable_bit)
    else $error("software enable write lost");

endmodule // ceia_exc_unit

// [verilog/ceia_pkg.sv]
package ceia_pkg;

  // request presented by the external interrupt controller
  typedef struct packed {
    logic [31:0] req_handler_addr;
    logic [5:0]  req_reg_set;
    logic [5:0]  req_irq_level;
    logic        req_nonmaskable;
  } ceia_ext_irq_ctrl_iface_t;

  // processor status word, bit 0 is the interrupt enable
  typedef struct packed {
    logic       exception_in_progress;
    logic       nmi_in_progress;
    logic       same_set_nest_enable;
    logic [5:0] current_reg_set;
    logic [5:0] current_irq_level;
    logic       irq_enable_bit;
  } ceia_stat_t;

  // bus-side states of the slave
  typedef enum logic [2:0] {
    CEIA_BUS_IDLE  = 3'b001,
    CEIA_BUS_RWAIT = 3'b010,
    CEIA_BUS_RDATA = 3'b100
  } ceia_bus_st_t;

endpackage
